// >>> dv/card_model.sv
// Behavioural smart card on the shared data line; it only ever pulls low
`default_nettype none
module card_model (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 1488;  // 372 base clocks of 4 system clocks
  initial o_low = 1'b0;
  // Card sends a character, then looks for an error signal in the guard time
  task automatic send(input logic [7:0] b, input bit bad, output bit nak);
    logic [9:0] f;
    f = {(^b) ^ bad, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      o_low <= !f[i];
      repeat (BIT) @(posedge i_clk);
    end
    o_low <= 1'b0;  // Released: the pull-up takes the line high
    repeat (BIT) @(posedge i_clk);
    nak = !i_line;
    // A few cycles beyond the guard bit, so the receiver has closed its frame
    repeat (BIT + 16) @(posedge i_clk);
  endtask
  // Card reads a character and may refuse it in the error slot
  task automatic take(input bit nak, output logic [7:0] b, output logic p, output bit tmo);
    int n;
    n = 0;
    while (i_line && n < 40000)
    begin
      @(posedge i_clk);
      n++;
    end
    tmo = (n == 40000);
    repeat (BIT / 2) @(posedge i_clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge i_clk);
      if (i < 8)
        b[i] = i_line;
      else
        p = i_line;
    end
    repeat (BIT) @(posedge i_clk);
    o_low <= nak;
    repeat (BIT) @(posedge i_clk);
    o_low <= 1'b0;
    repeat (BIT + BIT / 2 - 100) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// >>> dv/scard_checker_assertions.sv
// Port checker for the card serial unit, bound to its top module
`include "scard_defines.svh"
`default_nettype none
module scard_checker (
  input  wire logic       I_CLK,
  input  wire logic       I_NRST,
  input  wire logic [2:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic [7:0] O_RDATA,
  input  wire logic       I_DATA,
  input  wire logic       O_DATA_OUT,
  input  wire logic       O_DATA_OE,
  input  wire logic       O_CARD_CLK,
  input  wire logic       O_TX_READY_IRQ,
  input  wire logic       O_RX_READY_IRQ,
  input  wire logic       O_LINK_ERROR_IRQ,
  input  wire logic       O_TX_FINISH_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  ctrl_r;
  logic        gsm_r;
  logic [3:0]  off_r;
  logic [10:0] oe_r;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // Shadow of control and mode bits, seen on the register port
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      ctrl_r <= 8'h00;
      gsm_r  <= 1'b0;
    end
    else if (I_WR && I_ADDR == `SC_OFF_CTRL)
      ctrl_r <= I_WDATA;
    else if (I_WR && I_ADDR == `SC_OFF_MODE)
      gsm_r <= I_WDATA[`SC_MODE_GSM];
  end
  // Cycles since the clock enable went off; any control write restarts it
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      off_r <= 4'h0;
    else if (I_WR && I_ADDR == `SC_OFF_CTRL)
      off_r <= 4'h0;
    else if (!ctrl_r[`SC_CTRL_CKOE] && off_r != 4'hF)
      off_r <= off_r + 4'h1;
  end
  // Length of the current drive on the data line; wraps harmlessly during transmit
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      oe_r <= 11'h000;
    else
      oe_r <= O_DATA_OE ? oe_r + 11'h001 : 11'h000;
  end
  AST_NO_FINISH: assert property (!O_TX_FINISH_IRQ)
    else $error("finish request raised in card mode");
  AST_CLK_HIGH: assert property ($rose(O_CARD_CLK) && ctrl_r[`SC_CTRL_CKOE] |=>
    O_CARD_CLK ##1 !O_CARD_CLK)
    else $error("card clock high phase not two cycles");
  AST_CLK_LOW: assert property ($fell(O_CARD_CLK) |=> !O_CARD_CLK)
    else $error("card clock low phase cut short");
  AST_CLK_FIXED: assert property (gsm_r && off_r > 4'h6 |->
    O_CARD_CLK == ctrl_r[`SC_CTRL_CKSEL])
    else $error("card clock not held at selected level");
  AST_TX_MASK: assert property (!ctrl_r[`SC_CTRL_TIE] && $past(!ctrl_r[`SC_CTRL_TIE]) |->
    !O_TX_READY_IRQ)
    else $error("tx request while disabled");
  AST_RX_MASK: assert property (!ctrl_r[`SC_CTRL_RIE] && $past(!ctrl_r[`SC_CTRL_RIE]) |->
    !O_RX_READY_IRQ && !O_LINK_ERROR_IRQ)
    else $error("rx or error request while disabled");
  AST_RX_LOW: assert property (O_DATA_OE && !ctrl_r[`SC_CTRL_TE] |-> !O_DATA_OUT)
    else $error("receiver drives the line high");
  AST_NAK_LEN: assert property ($fell(O_DATA_OE) && !ctrl_r[`SC_CTRL_TE] |->
    oe_r == 11'h5D0)
    else $error("error signal not one bit long");
  cover property ($rose(O_RX_READY_IRQ));
  cover property ($rose(O_LINK_ERROR_IRQ));
  cover property ($rose(O_DATA_OE) && !ctrl_r[`SC_CTRL_TE]);
  cover property ($rose(O_TX_READY_IRQ));
endmodule
bind smart_card_serial_interface scard_checker u_chk (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_DATA(I_DATA), .O_DATA_OUT(O_DATA_OUT), .O_DATA_OE(O_DATA_OE), .O_CARD_CLK(O_CARD_CLK),
  .O_TX_READY_IRQ(O_TX_READY_IRQ), .O_RX_READY_IRQ(O_RX_READY_IRQ),
  .O_LINK_ERROR_IRQ(O_LINK_ERROR_IRQ), .O_TX_FINISH_IRQ(O_TX_FINISH_IRQ));
`default_nettype wire

// >>> dv/smart_card_serial_interface_tb.sv
// Self-checking bench for the card serial unit with a card on the data line
`include "scard_defines.svh"
`default_nettype none
module smart_card_serial_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata, b, got;
  logic       dout, oe, card_clk, tx_irq, rx_irq, err_irq, card_low, p, fin;
  bit         nak, tmo;
  int         mismatches = 0;
  int         total_checks = 0;
  // Open-drain line with pull-up
  wire logic line = !(card_low || (oe && !dout));
  always #4 clk = ~clk;
  smart_card_serial_interface dut (.I_CLK(clk), .I_NRST(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_DATA(line),
    .O_DATA_OUT(dout), .O_DATA_OE(oe), .O_CARD_CLK(card_clk), .O_TX_READY_IRQ(tx_irq),
    .O_RX_READY_IRQ(rx_irq), .O_LINK_ERROR_IRQ(err_irq), .O_TX_FINISH_IRQ(fin));
  card_model card (.i_clk(clk), .i_line(line), .o_low(card_low));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    // One idle edge, so a following write never re-raises the strobe in the same step
    @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
    @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    void'($urandom(80955));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`SC_OFF_FLAGS, 8'h84, "flags reset");
    rd_chk(3'h7, 8'h00, "unmapped");
    // No DMA unit in this bench, so the serial settings simply come first
    wr_reg(`SC_OFF_CARD, 8'h01);
    wr_reg(`SC_OFF_MODE, 8'h80);
    wr_reg(`SC_OFF_CTRL, 8'h51);
    // Good character from the card
    b = 8'($urandom);
    card.send(b, 1'b0, nak);
    chk("nak good", 8'h00, {7'h00, nak});
    rd_chk(`SC_OFF_FLAGS, 8'hC4, "flags rx");
    chk("rx irq", 8'h01, {7'h00, rx_irq});
    rd_chk(`SC_OFF_RXBUF, b, "rx data");
    rd_chk(`SC_OFF_FLAGS, 8'h84, "flags read");
    // Character with a parity fault: refused, flag kept until software clears it
    b = 8'($urandom);
    card.send(b, 1'b1, nak);
    chk("nak bad", 8'h01, {7'h00, nak});
    rd_chk(`SC_OFF_FLAGS, 8'h8C, "flags per");
    chk("err irq", 8'h01, {7'h00, err_irq});
    repeat (100) @(posedge clk);
    rd_chk(`SC_OFF_FLAGS, 8'h8C, "flags hold");
    wr_reg(`SC_OFF_FLAGS, 8'h00);
    rd_chk(`SC_OFF_FLAGS, 8'h84, "flags clr");
    // Re-initialise for transmit
    wr_reg(`SC_OFF_CTRL, 8'h00);
    wr_reg(`SC_OFF_CTRL, 8'hE1);
    rd_chk(`SC_OFF_FLAGS, 8'h84, "tx idle");
    chk("tx irq", 8'h01, {7'h00, tx_irq});
    b = 8'($urandom);
    wr_reg(`SC_OFF_TXBUF, b);
    rd_chk(`SC_OFF_FLAGS, 8'h00, "tx busy");
    // First frame refused by the card, second accepted
    for (int k = 0; k < 2; k++)
    begin
      card.take(k == 0, got, p, tmo);
      chk("timeout", 8'h00, {7'h00, tmo});
      if (tmo)
        break;
      chk("tx data", b, got);
      chk("tx parity", {7'h00, ^b}, {7'h00, p});
      repeat (200) @(posedge clk);
      rd_chk(`SC_OFF_FLAGS, k == 0 ? 8'h10 : 8'h84, "flags tx");
      chk("tx irq end", 8'(k), {7'h00, tx_irq});
      if (k == 0)
      begin
        chk("ers irq", 8'h01, {7'h00, err_irq});
        wr_reg(`SC_OFF_FLAGS, 8'h00);
      end
    end
    // Clock held at each level, then restarted
    for (int s = 0; s < 2 && !tmo; s++)
    begin
      wr_reg(`SC_OFF_CTRL, {6'h00, s[0], 1'b0});
      repeat (12) @(posedge clk);
      #1;
      chk("card clk", 8'(s), {7'h00, card_clk});
      // Level select kept at the held pin level, so the restart has no glitch
      wr_reg(`SC_OFF_CTRL, {6'h00, s[0], 1'b1});
      repeat (12) @(posedge clk);
    end
    wr_reg(`SC_OFF_MODE, 8'h00);
    chk("finish irq", 8'h00, {7'h00, fin});
    stop_test();
  end
endmodule
`default_nettype wire

// >>> logic/scard_defines.svh
// Register offsets, field positions, reset values and timing counts of the card serial unit
`ifndef SCARD_DEFINES_SVH
`define SCARD_DEFINES_SVH
// Register offsets on the plain register port
`define SC_OFF_MODE      3'h0
`define SC_OFF_CTRL      3'h1
`define SC_OFF_TXBUF     3'h2
`define SC_OFF_FLAGS     3'h3
`define SC_OFF_RXBUF     3'h4
`define SC_OFF_CARD      3'h5
// serial_mode_reg fields
`define SC_MODE_GSM      7
`define SC_MODE_ODD      1
// serial_control_reg fields
`define SC_CTRL_TIE      7
`define SC_CTRL_RIE      6
`define SC_CTRL_TE       5
`define SC_CTRL_RE       4
`define SC_CTRL_CKSEL    1
`define SC_CTRL_CKOE     0
// serial_flags_reg fields
`define SC_FLG_TDE       7
`define SC_FLG_RDF       6
`define SC_FLG_ORE       5
`define SC_FLG_ERS       4
`define SC_FLG_PER       3
`define SC_FLG_TDONE     2
// card_mode_reg field
`define SC_CARD_EN       0
// Reset values
`define SC_RST_REG       8'h00
`define SC_RST_FLAGS     8'h84
// Timing: base clocks per bit, sample points, system clocks per base clock
`define SC_BIT_BASE      9'h174
`define SC_SAMPLE_POINT  9'h0B9
`define SC_ERR_SAMPLE    9'h05D
`define SC_BASE_DIV      3'h4
`define SC_BASE_HALF     3'h2
`define SC_LAST_BIT      4'hC
`endif

// >>> logic/scard_pkg.sv
// Types shared by the card serial unit
`default_nettype none
package scard_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} xfer_state_t;
endpackage
`default_nettype wire

// >>> logic/smart_card_serial_interface.sv
// Smart card mode of the serial unit: registers, frame engine, card clock and requests
//
// Overview of operation
// - In gsm clock mode the card clock can be fixed keeping its full pulse width.
// - Only three requests exist in card mode; tx_finish_irq always stays low.
// - tx_ready_irq follows tx_done while tx_irq_enable is set; usable by DMA.
// - rx_ready_irq follows rx_buffer_full while rx_irq_enable is set; usable by DMA.
// - link_error_irq follows any error flag while rx_irq_enable is set; never DMA.
// - tx_done and tx_buffer_empty set together; a tx_buffer write clears both.
// - Hardware never clears error_signal_flag or parity_error_flag; software does.
// - Reading rx_buffer clears rx_buffer_full.
// - A receive error sets an error flag instead of rx_buffer_full.
// - In gsm mode clearing clock enable ends the running period, then holds the selected level; otherwise the clock stops at once.
// - Re-enabling the clock restarts it at a period boundary with normal duty.
// - Bits last 372 base clocks; reception syncs on the sampled start bit fall.
// - Each received bit is latched on the 186th base clock of its bit.
// - A parity error sets parity_error_flag and withholds rx_buffer_full.
// - Correct parity sets rx_buffer_full and leaves parity_error_flag clear.
// - After a good frame the data line stays released during the error slot.
// - A card error signal sets error_signal_flag, withholds tx_done, resends the byte.
// - No error signal means the byte is done: tx_done is set.
//
// Added by the designer: the register addresses and the plain strobed port.
`include "scard_defines.svh"
`default_nettype none
module smart_card_serial_interface (
  input  wire logic       I_CLK,
  input  wire logic       I_NRST,
  input  wire logic [2:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  input  wire logic       I_DATA,
  output logic            O_DATA_OUT,
  output logic            O_DATA_OE,
  output logic            O_CARD_CLK,
  output logic            O_TX_READY_IRQ,
  output logic            O_RX_READY_IRQ,
  output logic            O_LINK_ERROR_IRQ,
  output logic            O_TX_FINISH_IRQ
);

  logic [7:0]               mode_r;
  logic [7:0]               ctrl_r;
  logic [7:0]               card_r;
  logic [7:0]               txbuf_r;
  logic [7:0]               rxbuf_r;
  logic [7:0]               flags_r;
  logic [7:0]               flags_nxt;
  logic [2:0]               div_r;
  logic                     base_tick;
  logic                     ck_run_r;
  logic                     d_s1_r;
  logic                     d_s2_r;
  logic                     d_prev_r;
  scard_pkg::xfer_state_t   st_r;
  logic [8:0]               etu_r;
  logic [3:0]               bit_r;
  logic [7:0]               shift_r;
  logic                     par_bad_r;
  logic                     card_err_r;
  logic                     frame_end;
  logic                     wr_tx;
  logic                     rd_rx;
  logic                     card_on;

  // Parity of a byte under the selected odd or even sense
  function automatic logic par_of(input logic [7:0] b, input logic odd);
    par_of = (^b) ^ odd;
  endfunction

  assign wr_tx   = I_WR && (I_ADDR == `SC_OFF_TXBUF);
  assign rd_rx   = I_RD && (I_ADDR == `SC_OFF_RXBUF);
  assign card_on = card_r[`SC_CARD_EN];

  // Software-written configuration registers
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      mode_r  <= `SC_RST_REG;
      ctrl_r  <= `SC_RST_REG;
      card_r  <= `SC_RST_REG;
      txbuf_r <= `SC_RST_REG;
    end
    else if (I_WR)
    begin
      case (I_ADDR)
        `SC_OFF_MODE:  mode_r  <= I_WDATA;
        `SC_OFF_CTRL:  ctrl_r  <= I_WDATA;
        `SC_OFF_CARD:  card_r  <= I_WDATA;
        `SC_OFF_TXBUF: txbuf_r <= I_WDATA;
        default:       ;
      endcase
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_RDATA <= 8'h00;
    else if (I_RD)
    begin
      case (I_ADDR)
        `SC_OFF_MODE:  O_RDATA <= mode_r;
        `SC_OFF_CTRL:  O_RDATA <= ctrl_r;
        `SC_OFF_TXBUF: O_RDATA <= txbuf_r;
        `SC_OFF_FLAGS: O_RDATA <= flags_r;
        `SC_OFF_RXBUF: O_RDATA <= rxbuf_r;
        `SC_OFF_CARD:  O_RDATA <= card_r;
        default:       O_RDATA <= 8'h00;
      endcase
    end
    else
      O_RDATA <= 8'h00;
  end

  // Base clock divider; it also paces the card clock so both share one period
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      div_r <= 3'h0;
    else if (div_r == `SC_BASE_DIV - 3'h1)
      div_r <= 3'h0;
    else
      div_r <= div_r + 3'h1;
  end
  assign base_tick = (div_r == `SC_BASE_DIV - 3'h1);

  // Card clock run flag changes at a period boundary to protect the duty cycle, except that clearing clock enable outside gsm mode drops it at once
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      ck_run_r <= 1'b0;
    else if (!ctrl_r[`SC_CTRL_CKOE] && !mode_r[`SC_MODE_GSM])
      ck_run_r <= 1'b0;
    else if (base_tick)
      ck_run_r <= ctrl_r[`SC_CTRL_CKOE] && card_on;
  end

  // Card clock pin: high half then low half; fixed level while stopped
  // A start, or a stop in gsm mode, takes effect on the boundary edge itself, so the first high half is full
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_CARD_CLK <= 1'b0;
    else if (base_tick ? (ctrl_r[`SC_CTRL_CKOE] && card_on) : ck_run_r)
      O_CARD_CLK <= (div_r == `SC_BASE_DIV - 3'h1) || (div_r < `SC_BASE_HALF - 3'h1);
    else
      O_CARD_CLK <= ctrl_r[`SC_CTRL_CKSEL];
  end

  // Data line synchroniser plus one stage for the start edge
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      d_s1_r   <= 1'b1;
      d_s2_r   <= 1'b1;
      d_prev_r <= 1'b1;
    end
    else
    begin
      d_s1_r   <= I_DATA;
      d_s2_r   <= d_s1_r;
      d_prev_r <= d_s2_r;
    end
  end

  assign frame_end = base_tick && (etu_r == `SC_BIT_BASE - 9'h001) &&
                     (((st_r == scard_pkg::ST_RX) && (bit_r == `SC_LAST_BIT - 4'h1)) ||
                      ((st_r == scard_pkg::ST_TX) && (bit_r == `SC_LAST_BIT)));

  // Frame sequencer: state, base clock count within a bit, bit index
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      st_r  <= scard_pkg::ST_IDLE;
      etu_r <= 9'h000;
      bit_r <= 4'h0;
    end
    else if (!card_on)
      st_r <= scard_pkg::ST_IDLE;
    else
    begin
      case (st_r)
        scard_pkg::ST_IDLE:
        begin
          etu_r <= 9'h000;
          bit_r <= 4'h0;
          if (ctrl_r[`SC_CTRL_TE] && !flags_r[`SC_FLG_TDE] && !wr_tx && base_tick)
            st_r <= scard_pkg::ST_TX;
          else if (ctrl_r[`SC_CTRL_RE] && d_prev_r && !d_s2_r)
            st_r <= scard_pkg::ST_RX;
        end
        scard_pkg::ST_RX, scard_pkg::ST_TX:
        begin
          if (frame_end)
            st_r <= scard_pkg::ST_IDLE;
          else if ((st_r == scard_pkg::ST_RX) && base_tick && (bit_r == 4'h0) &&
                   (etu_r == `SC_SAMPLE_POINT) && d_s2_r)
            st_r <= scard_pkg::ST_IDLE; // False start: line back high at sample point
          if (base_tick)
          begin
            if (etu_r == `SC_BIT_BASE - 9'h001)
            begin
              etu_r <= 9'h000;
              bit_r <= bit_r + 4'h1;
            end
            else
              etu_r <= etu_r + 9'h001;
          end
        end
        default: st_r <= scard_pkg::ST_IDLE;
      endcase
    end
  end

  // Shift register and parity/error-signal verdicts
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      shift_r    <= 8'h00;
      par_bad_r  <= 1'b0;
      card_err_r <= 1'b0;
    end
    else if (st_r == scard_pkg::ST_IDLE)
    begin
      shift_r    <= txbuf_r; // Reloaded every time, so a retry resends the same byte
      par_bad_r  <= 1'b0;
      card_err_r <= 1'b0;
    end
    else if (base_tick && (st_r == scard_pkg::ST_RX) && (etu_r == `SC_SAMPLE_POINT))
    begin
      if ((bit_r >= 4'h1) && (bit_r <= 4'h8))
        shift_r <= {d_s2_r, shift_r[7:1]};
      if (bit_r == 4'h9)
        par_bad_r <= (d_s2_r != par_of(shift_r, mode_r[`SC_MODE_ODD]));
    end
    else if (base_tick && (st_r == scard_pkg::ST_TX) && (bit_r == 4'hB) &&
             (etu_r == `SC_ERR_SAMPLE))
      card_err_r <= !d_s2_r; // Card holds the line low in the error slot
  end

  // Data pin driver: transmit bits, or a low error pulse after a bad parity
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_DATA_OUT <= 1'b1;
      O_DATA_OE  <= 1'b0;
    end
    else if ((st_r == scard_pkg::ST_TX) && (bit_r <= 4'h9) && !frame_end)
    begin
      O_DATA_OE <= 1'b1;
      if (bit_r == 4'h0)
        O_DATA_OUT <= 1'b0;
      else if (bit_r == 4'h9)
        O_DATA_OUT <= par_of(shift_r, mode_r[`SC_MODE_ODD]);
      else
        O_DATA_OUT <= shift_r[bit_r[2:0] - 3'h1];
    end
    else if ((st_r == scard_pkg::ST_RX) && par_bad_r &&
             (((bit_r == 4'hA) && (etu_r >= `SC_SAMPLE_POINT + 9'h001)) ||
              ((bit_r == 4'hB) && (etu_r <= `SC_SAMPLE_POINT))))
    begin
      O_DATA_OE  <= 1'b1;
      O_DATA_OUT <= 1'b0;
    end
    else
    begin
      O_DATA_OE  <= 1'b0;
      O_DATA_OUT <= 1'b1;
    end
  end

  // Status flags; a hardware set always wins over a software clear in the same cycle
  always_comb
  begin
    flags_nxt = flags_r;
    if (I_WR && (I_ADDR == `SC_OFF_FLAGS))
    begin
      flags_nxt[`SC_FLG_ORE] = flags_r[`SC_FLG_ORE] & I_WDATA[`SC_FLG_ORE];
      flags_nxt[`SC_FLG_ERS] = flags_r[`SC_FLG_ERS] & I_WDATA[`SC_FLG_ERS];
      flags_nxt[`SC_FLG_PER] = flags_r[`SC_FLG_PER] & I_WDATA[`SC_FLG_PER];
    end
    if (wr_tx)
    begin
      flags_nxt[`SC_FLG_TDE]   = 1'b0;
      flags_nxt[`SC_FLG_TDONE] = 1'b0;
    end
    if (rd_rx)
      flags_nxt[`SC_FLG_RDF] = 1'b0;
    if (frame_end && (st_r == scard_pkg::ST_RX))
    begin
      if (par_bad_r)
        flags_nxt[`SC_FLG_PER] = 1'b1;
      else if (flags_r[`SC_FLG_RDF] && !rd_rx)
        flags_nxt[`SC_FLG_ORE] = 1'b1;
      else
        flags_nxt[`SC_FLG_RDF] = 1'b1;
    end
    if (frame_end && (st_r == scard_pkg::ST_TX))
    begin
      if (card_err_r)
        flags_nxt[`SC_FLG_ERS] = 1'b1;
      else
      begin
        flags_nxt[`SC_FLG_TDONE] = 1'b1;
        flags_nxt[`SC_FLG_TDE]   = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      flags_r <= `SC_RST_FLAGS;
    else
      flags_r <= flags_nxt;
  end

  // Received byte is kept even on a parity error so software may inspect it
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      rxbuf_r <= 8'h00;
    else if (frame_end && (st_r == scard_pkg::ST_RX) &&
             (par_bad_r || !flags_r[`SC_FLG_RDF] || rd_rx))
      rxbuf_r <= shift_r;
  end

  // Request lines; only the data requests suit DMA, the error one goes to the processor
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_TX_READY_IRQ   <= 1'b0;
      O_RX_READY_IRQ   <= 1'b0;
      O_LINK_ERROR_IRQ <= 1'b0;
      O_TX_FINISH_IRQ  <= 1'b0;
    end
    else
    begin
      O_TX_READY_IRQ   <= flags_r[`SC_FLG_TDONE] && ctrl_r[`SC_CTRL_TIE];
      O_RX_READY_IRQ   <= flags_r[`SC_FLG_RDF] && ctrl_r[`SC_CTRL_RIE];
      O_LINK_ERROR_IRQ <= (flags_r[`SC_FLG_ORE] || flags_r[`SC_FLG_PER] ||
                           flags_r[`SC_FLG_ERS]) && ctrl_r[`SC_CTRL_RIE];
      O_TX_FINISH_IRQ  <= 1'b0;
    end
  end

endmodule
`default_nettype wire
